//--- fcl_map.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by files that need the register map of the fan limit bank
`ifndef FCL_MAP_SVH
`define FCL_MAP_SVH
`define FCL_OFF_FAN1_CEIL 8'h38
`define FCL_OFF_FAN2_CEIL 8'h39
`define FCL_OFF_FAN3_CEIL 8'h3A
`define FCL_OFF_MAIN_CFG 8'h40
`define FCL_OFF_DYN_CTL1 8'h36
`define FCL_OFF_INTERVAL 8'h37
`define FCL_OFF_CFG4 8'h7D
`define FCL_RST_CEIL 8'hFF
`define FCL_RST_MAIN_CFG 8'h01
`define FCL_RST_DYN_CTL1 8'h00
`define FCL_RST_INTERVAL 8'h00
`define FCL_RST_CFG4 8'h00
`define FCL_FULL_DUTY 8'hFF
`define FCL_BIT_RUN 0
`define FCL_BIT_LOCK 1
`define FCL_BIT_READY 2
`define FCL_BIT_FULL 3
`define FCL_BIT_PWR 4
`define FCL_BIT_SPIN 5
`define FCL_BIT_TMO 6
`define FCL_BIT_ALARM_CEIL 3
`define FCL_BIT_CODE_MSB 7
`define FCL_INT_LSB 6
`define FCL_DEC_BASE 8
`define FCL_INC_BASE 16
`define FCL_READY_CYCLES 16
`endif

//--- fcl_pkg.sv
// Types shared by the fan limit bank
// Assumes fcl_map.svh supplies the numeric constants
package fcl_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} fcl_req_t;
	typedef struct packed {
		logic bus_timeout_ctl;
		logic spinup_detect_off;
		logic power_report_flag;
		logic all_fans_full;
		logic ready;
		logic lock;
		logic monitor_run;
	} fcl_cfg_t;
	typedef enum logic [1:0] {
		FCL_WAIT = 2'b00,
		FCL_DEC = 2'b01,
		FCL_INC = 2'b10
	} fcl_adj_t;
endpackage

//--- fcl_interval.sv
// Monitoring-cycle counter that paces fan start temperature adjustments
// Assumes mon_tick is a one-cycle pulse per monitoring cycle on mclk
`timescale 1ns/100ps
`include "fcl_map.svh"
module fcl_interval
	import fcl_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic mon_tick,
	input wire logic [2:0] code,
	input wire logic dir_up,
	output logic adjust
);
	logic [11:0] cnt_q;
	logic [11:0] limit;
	always_comb begin
		// Decrease waits 8 << code, increase twice that
		if (dir_up)
			limit = 12'(`FCL_INC_BASE) << code; // RULE1
		else
			limit = 12'(`FCL_DEC_BASE) << code; // RULE1
	end
	always_ff @(posedge mclk) begin
		if (!rst_n || !enable) begin
			cnt_q <= 12'h000;
			adjust <= 1'b0;
		end else begin
			adjust <= 1'b0;
			if (mon_tick) begin
				if (cnt_q + 12'h001 >= limit) begin
					cnt_q <= 12'h000;
					adjust <= 1'b1; // RULE2
				end else begin
					cnt_q <= cnt_q + 12'h001;
				end
			end
		end
	end
endmodule // fcl_interval

//--- fcl_bank.sv
// Configuration, lock and duty ceiling registers of the fan controller
// Assumes the serial bus engine outside delivers one-cycle register strobes on mclk
`timescale 1ns/100ps
`include "fcl_map.svh"
// What this block does
// RULE1 - Interval code picks 8/16 doubling to 1024/2048
// RULE2 - Code paces adjustments; MSB in dynamic control
// RULE3 - Lock makes lockable registers ignore writes
// RULE4 - Three duty ceilings at fan1_duty_ceiling-fan3_duty_ceiling, reset FF
// RULE5 - Ceiling caps each fan drive duty
// RULE6 - Alarm with config4 bit3 drives ceilings
// RULE7 - Alarm with bit3 clear forces full duty
// RULE8 - Main config at 0x40 resets to 0x01
// RULE9 - Run bit set uses programmed limits
// RULE10 - Run bit clear uses power-up limits
// RULE11 - Run bit stays writable when locked
// RULE12 - Lock bit write-once, cleared only at power-on
// RULE13 - Ready bit read-only, set once powered
// RULE14 - Full-speed bit resets 0, never locked
// RULE15 - Power report flag lockable, no control effect
// RULE16 - Spin-up detect off holds drive high
// RULE17 - Bus timeout enable bit, lockable
// RULE18 - Bit7 zero; duty is min(command, ceiling)
module fcl_bank
	import fcl_pkg::*;
#(
	parameter int FANS = 3
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire fcl_req_t req,
	output logic [7:0] rdata,
	input wire logic mon_tick,
	input wire logic thermal_alarm_pin_n,
	input wire logic [FANS*8-1:0] duty_cmd,
	input wire logic adj_dir_up,
	output logic [FANS*8-1:0] duty_out,
	output logic adjust_now,
	output fcl_cfg_t cfg,
	output logic [2:0] adjust_interval_code,
	output logic spin_hold_high
);
	logic [7:0] ceil_q [FANS];
	logic [7:0] dyn_ctl1_q;
	logic [7:0] interval_q;
	logic [7:0] cfg4_q;
	logic run_q;
	logic lock_q;
	logic ready_q;
	logic full_q;
	logic pwr_q;
	logic spin_q;
	logic tmo_q;
	logic [4:0] ready_cnt_q;
	logic alarm_s1_q;
	logic alarm_s2_q;
	logic [2:0] code;
	logic adjust;
	logic wr_ok;
	logic sel_dyn;
	logic sel_int;
	logic sel_cfg4;
	logic sel_main;
	logic [FANS-1:0] sel_ceil;
	logic main_wr;
	logic main_wr_lockable;
	logic alarm_on;
	logic alarm_ceil_mode;
	logic [7:0] main_view;
	logic [7:0] rdata_d;

	// One decode feeds both the write and the read path
	always_comb begin
		sel_dyn = (req.addr == `FCL_OFF_DYN_CTL1);
		sel_int = (req.addr == `FCL_OFF_INTERVAL);
		sel_cfg4 = (req.addr == `FCL_OFF_CFG4);
		sel_main = (req.addr == `FCL_OFF_MAIN_CFG);
	end

	// Lockable writes are refused once the lock is set
	assign wr_ok = req.wr && !lock_q; // RULE3
	assign main_wr = req.wr && sel_main;
	assign main_wr_lockable = wr_ok && sel_main; // RULE3
	assign code = {dyn_ctl1_q[`FCL_BIT_CODE_MSB], interval_q[`FCL_INT_LSB+1:`FCL_INT_LSB]}; // RULE2
	assign alarm_on = alarm_s2_q;
	assign alarm_ceil_mode = cfg4_q[`FCL_BIT_ALARM_CEIL];
	// Reserved top bit always reads back as zero
	assign main_view = {1'b0, tmo_q, spin_q, pwr_q, full_q, ready_q, lock_q, run_q}; // RULE18

	// Alarm pin is from outside the clock domain
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			alarm_s1_q <= 1'b0;
			alarm_s2_q <= 1'b0;
		end else begin
			alarm_s1_q <= !thermal_alarm_pin_n;
			alarm_s2_q <= alarm_s1_q;
		end
	end

	genvar g;
	generate
		for (g = 0; g < FANS; g++) begin : g_fan
			logic [7:0] ceil_use;
			logic [7:0] cmd;
			logic [7:0] limited;
			logic [7:0] duty_d;
			assign cmd = duty_cmd[g*8 +: 8];
			assign sel_ceil[g] = (req.addr == `FCL_OFF_FAN1_CEIL + 8'(g));
			// Stopped monitoring falls back to power-up ceiling
			assign ceil_use = run_q ? ceil_q[g] : `FCL_RST_CEIL; // RULE9 RULE10
			assign limited = (cmd < ceil_use) ? cmd : ceil_use; // RULE5 RULE18

			// Full speed outranks the alarm, the alarm outranks the ceiling
			always_comb begin
				if (full_q)
					duty_d = `FCL_FULL_DUTY; // RULE14
				else if (alarm_on && alarm_ceil_mode)
					duty_d = ceil_use; // RULE6
				else if (alarm_on)
					duty_d = `FCL_FULL_DUTY; // RULE7
				else
					duty_d = limited; // RULE18
			end

			always_ff @(posedge mclk) begin
				if (!rst_n)
					ceil_q[g] <= `FCL_RST_CEIL; // RULE4
				else if (wr_ok && sel_ceil[g])
					ceil_q[g] <= req.wdata; // RULE4 RULE3
			end

			always_ff @(posedge mclk) begin
				if (!rst_n)
					duty_out[g*8 +: 8] <= 8'h00;
				else
					duty_out[g*8 +: 8] <= duty_d;
			end
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (!rst_n)
			dyn_ctl1_q <= `FCL_RST_DYN_CTL1;
		else if (wr_ok && sel_dyn)
			dyn_ctl1_q <= req.wdata; // RULE3
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			interval_q <= `FCL_RST_INTERVAL;
		else if (wr_ok && sel_int)
			interval_q <= req.wdata; // RULE3
	end

	// Alarm ceiling mode is lockable like the ceilings it selects
	always_ff @(posedge mclk) begin
		if (!rst_n)
			cfg4_q <= `FCL_RST_CFG4;
		else if (wr_ok && sel_cfg4)
			cfg4_q <= req.wdata; // RULE3
	end

	// Run and full speed ignore the lock, so a locked system can still be stopped or cooled hard
	always_ff @(posedge mclk) begin
		if (!rst_n)
			run_q <= 1'((`FCL_RST_MAIN_CFG >> `FCL_BIT_RUN) & 8'h01); // RULE8
		else if (main_wr)
			run_q <= req.wdata[`FCL_BIT_RUN]; // RULE11
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			full_q <= 1'((`FCL_RST_MAIN_CFG >> `FCL_BIT_FULL) & 8'h01); // RULE14
		else if (main_wr)
			full_q <= req.wdata[`FCL_BIT_FULL]; // RULE14
	end

	// Lockable main configuration bits
	always_ff @(posedge mclk) begin
		if (!rst_n)
			pwr_q <= 1'((`FCL_RST_MAIN_CFG >> `FCL_BIT_PWR) & 8'h01);
		else if (main_wr_lockable)
			pwr_q <= req.wdata[`FCL_BIT_PWR]; // RULE15
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			spin_q <= 1'((`FCL_RST_MAIN_CFG >> `FCL_BIT_SPIN) & 8'h01);
		else if (main_wr_lockable)
			spin_q <= req.wdata[`FCL_BIT_SPIN]; // RULE16
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			tmo_q <= 1'((`FCL_RST_MAIN_CFG >> `FCL_BIT_TMO) & 8'h01);
		else if (main_wr_lockable)
			tmo_q <= req.wdata[`FCL_BIT_TMO]; // RULE17
	end

	// Only rst_n (power-on) clears the lock; writes can only set it
	always_ff @(posedge mclk) begin
		if (!rst_n)
			lock_q <= 1'b0;
		else if (main_wr && req.wdata[`FCL_BIT_LOCK])
			lock_q <= 1'b1; // RULE12
	end

	// Ready after a short settle; never written by the host
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ready_cnt_q <= 5'h00;
			ready_q <= 1'b0;
		end else if (!ready_q) begin
			if (ready_cnt_q == 5'(`FCL_READY_CYCLES - 1))
				ready_q <= 1'b1; // RULE13
			else
				ready_cnt_q <= ready_cnt_q + 5'h01;
		end
	end

	// Unmapped offsets read as zero so a stray probe never sees stale data
	always_comb begin
		rdata_d = 8'h00;
		if (sel_dyn)
			rdata_d = dyn_ctl1_q;
		if (sel_int)
			rdata_d = interval_q;
		if (sel_cfg4)
			rdata_d = cfg4_q;
		if (sel_main)
			rdata_d = main_view; // RULE18
		for (int i = 0; i < FANS; i++) begin
			if (sel_ceil[i])
				rdata_d = ceil_q[i]; // RULE4
		end
	end

	// Read data holds until the next read strobe
	always_ff @(posedge mclk) begin
		if (!rst_n)
			rdata <= 8'h00;
		else if (req.rd)
			rdata <= rdata_d;
	end

	// Registered copies so every output leaves from a flip-flop
	always_ff @(posedge mclk) begin
		if (!rst_n)
			cfg <= '0;
		else
			cfg <= '{tmo_q, spin_q, pwr_q, full_q, ready_q, lock_q, run_q};
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			adjust_interval_code <= 3'h0;
		else
			adjust_interval_code <= code; // RULE2
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			spin_hold_high <= 1'b0;
		else
			spin_hold_high <= spin_q; // RULE16
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			adjust_now <= 1'b0;
		else
			adjust_now <= adjust;
	end

	fcl_interval u_interval (
		.mclk(mclk),
		.rst_n(rst_n),
		.enable(run_q),
		.mon_tick(mon_tick),
		.code(code),
		.dir_up(adj_dir_up),
		.adjust(adjust)
	);
endmodule // fcl_bank

//--- fcl_host.sv
// Host model issuing register strobes to the bank
// Assumes strobes are taken on the rising edge of mclk
`timescale 1ns/100ps
module fcl_host
	import fcl_pkg::*;
(
	input wire logic mclk,
	input wire logic [7:0] rdata,
	output fcl_req_t req
);
	initial req = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		req <= '{a, d, 1'b1, 1'b0};
		@(negedge mclk);
		req <= '0;
	endtask
	// Read data is held until the next read, so sample late
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(negedge mclk);
		req <= '0;
		@(negedge mclk);
		d = rdata;
	endtask
endmodule // fcl_host

//--- fcl_checker.sv
// Port assertions for the fan limit bank
// Assumes bound to every fcl_bank instance
`timescale 1ns/100ps
module fcl_checker
	import fcl_pkg::*;
#(
	parameter int FANS = 3
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire fcl_req_t req,
	input wire logic [7:0] rdata,
	input wire logic thermal_alarm_pin_n,
	input wire logic [FANS*8-1:0] duty_cmd,
	input wire logic [FANS*8-1:0] duty_out,
	input wire logic adjust_now,
	input wire fcl_cfg_t cfg
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_LOCK_HOLD: assert property (cfg.lock |=> cfg.lock) else $error("lock dropped");
	AST_START: assert property ($rose(rst_n) |-> ##2 (cfg.monitor_run && !cfg.lock)) else $error("bad reset");
	AST_RDY_LATE: assert property ($rose(rst_n) |-> !cfg.ready [*8]) else $error("ready early");
	AST_FROZEN: assert property (cfg.lock |=> $stable({cfg.bus_timeout_ctl, cfg.spinup_detect_off,
		cfg.power_report_flag})) else $error("locked bit moved");
	AST_FULL: assert property (cfg.all_fans_full && $past(cfg.all_fans_full) |-> duty_out == {FANS{8'hFF}})
		else $error("not full");
	AST_RUN_OFF: assert property ((thermal_alarm_pin_n && !cfg.monitor_run && !cfg.all_fans_full) [*4]
		|-> duty_out == $past(duty_cmd)) else $error("limits used");
	AST_ADJ_IDLE: assert property (!cfg.monitor_run [*3] |-> !adjust_now) else $error("adjust idle");
	AST_GAP: assert property (adjust_now |=> !adjust_now [*7]) else $error("adjust gap");
	AST_BIT7: assert property (req.rd && req.addr == 8'h40 |=> !rdata[7]) else $error("bit7 set");
endmodule // fcl_checker
bind fcl_bank fcl_checker #(.FANS(FANS)) u_chk (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata),
	.thermal_alarm_pin_n(thermal_alarm_pin_n), .duty_cmd(duty_cmd), .duty_out(duty_out),
	.adjust_now(adjust_now), .cfg(cfg));

//--- tb.sv
// Self-checking bench for the fan limit bank
// Assumes fcl_host drives every register strobe
`timescale 1ns/100ps
module tb;
	import fcl_pkg::*;
	logic mclk = 0, rst_n = 0, tick_en = 0, mon_tick = 0, alarm_n = 1, up = 0;
	logic [23:0] cmd = 24'h1020C0;
	logic [23:0] duty;
	logic [7:0] rdata;
	logic [2:0] code;
	logic adj, spin;
	fcl_req_t req;
	fcl_cfg_t cfg;
	int mismatches = 0, n_tests = 0, cyc = 0;
	always #25 mclk = ~mclk;
	// Ticks every other cycle so a pulse never looks like a level
	always @(negedge mclk) mon_tick <= tick_en & ~mon_tick;
	fcl_host u_host (.mclk(mclk), .rdata(rdata), .req(req));
	fcl_bank u_dut (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata), .mon_tick(mon_tick),
		.thermal_alarm_pin_n(alarm_n), .duty_cmd(cmd), .adj_dir_up(up), .duty_out(duty),
		.adjust_now(adj), .cfg(cfg), .adjust_interval_code(code), .spin_hold_high(spin));
	task automatic conclude;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			mismatches++;
			conclude();
		end
	end
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		u_host.rd(a, v);
		chk(24'(v), 24'(e));
	endtask
	task automatic rst;
		@(negedge mclk);
		rst_n = 0;
		repeat (20) @(negedge mclk);
		rst_n = 1;
	endtask
	task automatic t_reset;
		rdc(8'h38, 8'hFF);
		rdc(8'h3A, 8'hFF);
		rdc(8'h40, 8'h01);
		repeat (20) @(negedge mclk);
		rdc(8'h40, 8'h05);
		rdc(8'h55, 8'h00);
	endtask
	task automatic t_ceil;
		u_host.wr(8'h38, 8'h80);
		rdc(8'h38, 8'h80);
		chk(duty, 24'h102080);
		u_host.wr(8'h40, 8'h00);
		repeat (4) @(negedge mclk);
		chk(duty, cmd);
		u_host.wr(8'h40, 8'h01);
		repeat (3) @(negedge mclk);
		chk(duty, 24'h102080);
	endtask
	task automatic t_bits;
		u_host.wr(8'h40, 8'hE9);
		rdc(8'h40, 8'h6D);
		chk(duty, 24'hFFFFFF);
		chk(24'({spin, cfg.bus_timeout_ctl}), 24'h3);
		u_host.wr(8'h40, 8'h01);
	endtask
	task automatic t_alarm;
		alarm_n = 0;
		repeat (5) @(negedge mclk);
		chk(duty, 24'hFFFFFF);
		u_host.wr(8'h7D, 8'h08);
		repeat (3) @(negedge mclk);
		chk(duty, 24'hFFFF80);
		alarm_n = 1;
		u_host.wr(8'h7D, 8'h00);
	endtask
	task automatic nxt(output int k);
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while (adj !== 1'b1 && k < 9000);
	endtask
	task automatic t_iv(input logic [2:0] c, input logic u, input int n);
		int k;
		u_host.wr(8'h36, {c[2], 7'h00});
		u_host.wr(8'h37, {c[1:0], 6'h00});
		up = u;
		tick_en = 1;
		nxt(k);
		nxt(k);
		nxt(k);
		chk(24'(k), 24'(2 * n));
		chk(24'(code), 24'(c));
		tick_en = 0;
	endtask
	task automatic t_lock;
		u_host.wr(8'h40, 8'h13);
		u_host.wr(8'h38, 8'h20);
		u_host.wr(8'h40, 8'h48);
		rdc(8'h38, 8'h80);
		rdc(8'h40, 8'h1E);
		rst();
		rdc(8'h38, 8'hFF);
		rdc(8'h40, 8'h01);
	endtask
	initial begin
		rst();
		t_reset();
		t_ceil();
		t_bits();
		t_alarm();
		t_iv(3'h0, 1'b0, 8);
		t_iv(3'h1, 1'b1, 32);
		t_iv(3'h4, 1'b0, 128);
		t_iv(3'h7, 1'b1, 2048);
		t_lock();
		conclude();
	end
endmodule // tb
